/* File: design/plof_pkg.sv */
// How it works
// - one network per output, each with up to nine contacts
// - each contact picks area and number from eight signal areas
// - destination is always physical outputs; the flag never selects controller inputs or internal registers
// - fifteen function codes selectable with positive or negative edge; the four counter codes and shift behave as standard
// - standard function copies network result straight to output
// - set-reset latch holds on set, reset wins when both true
// - data latch follows data while strobe is high
// - data latch keeps last data when strobe drops
// - toggle inverts output every scan while input true
// - toggle freezes output when input goes false
// - toggle reset forces output off and beats toggle input
// - six timer variants usable only with nonzero unspent timer budget
// - positive pulse timer ends at preset or when result falls
// - negative pulse timer drives low for preset after falling result
// - positive extended timer runs full preset, retriggered by rising edges
// - negative extended timer low at most preset, high at once on true
// - erasing an output network installs standard logic
// - erased network restored only by paste as the very next key
// - paste overwrites target, a second paste brings old network back
// - edits take effect at once while scanning continues
// - standard logic links every network n to cam n, none to inputs
// - preset time programmable 0.0 to 6553.5 ms
package plof_pkg;
  localparam int NET_CONTACTS = 9;
  localparam int AREA_COUNT   = 8;
  localparam int SIG_PER_AREA = 32;
  localparam int NUM_OUTS     = 8;
  localparam int TIMER_BUDGET = 4;
  localparam int TICK_NS      = 100000;
  localparam int CLK_NS       = 10;
  localparam int TICK_CYCLES  = TICK_NS / CLK_NS;
  localparam logic [15:0] PRESET_MAX = 16'hffff;
  localparam logic [15:0] PRESET_RST = 16'h1388;
  localparam logic [2:0] AREA_OUT  = 3'h0;
  localparam logic [2:0] AREA_IN   = 3'h1;
  localparam logic [2:0] AREA_CAM  = 3'h2;
  localparam logic [2:0] AREA_PIN  = 3'h3;
  localparam logic [1:0] DEST_OUT  = 2'h0;
  localparam logic [1:0] DEST_PIN  = 2'h1;
  localparam logic [1:0] DEST_REG  = 2'h2;

  typedef enum logic [3:0] {
    PLOF_STD, PLOF_SR, PLOF_DL, PLOF_TG,
    PLOF_PULSE_P, PLOF_PULSE_N, PLOF_EXT_P, PLOF_EXT_N,
    PLOF_ONDLY_P, PLOF_OFFDLY_N, PLOF_CNT_UP_P, PLOF_CNT_UP_N,
    PLOF_CNT_DN_P, PLOF_CNT_DN_N, PLOF_SHIFT
  } plof_func_e;

  typedef struct packed {
    logic       used;
    logic       inv;
    logic [2:0] area;
    logic [4:0] num;
  } plof_contact_s;

  typedef struct packed {
    plof_contact_s [8:0] ct;
    logic [8:0]  or_join;
    plof_func_e  func;
    plof_contact_s aux;
    logic [15:0] preset;
  } plof_net_s;

  typedef struct packed {
    logic        erase;
    logic        copy;
    logic        paste;
    logic        other;
    logic        write;
    logic [2:0]  sel;
    plof_net_s   net;
  } plof_edit_s;
endpackage : plof_pkg

/* File: design/plof_core.sv */
`timescale 1ns/1ps
`default_nettype none
module plof_core #(
  parameter int N_OUT  = plof_pkg::NUM_OUTS,
  parameter int BUDGET = plof_pkg::TIMER_BUDGET
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  // scan and signal areas
  input  wire logic                    scan_tick,
  input  wire logic [31:0]             phys_in,
  input  wire logic [31:0]             cam_out,
  input  wire logic [31:0]             ext_regs,
  // keypad edits
  input  wire plof_pkg::plof_edit_s    edit,
  // results
  output logic [N_OUT-1:0]             outs_r,
  output logic [1:0]                   net_dest_r,
  output logic                         timer_refused_r
);
  import plof_pkg::*;

  // the network index is three bits wide, so no more than eight networks are reachable
  if (N_OUT < 1 || N_OUT > 8 || BUDGET < 0) begin : g_bad_params
    $error("plof_core: N_OUT or BUDGET out of range");
  end

  plof_net_s  nets_r [N_OUT];
  plof_net_s  nets_nxt [N_OUT];
  plof_net_s  clip_r, clip_nxt, undo_r, undo_nxt;
  logic       undo_ok_r, undo_ok_nxt;
  logic [2:0] undo_sel_r, undo_sel_nxt;
  logic [N_OUT-1:0] res_prev_r, res_prev_nxt, outs_nxt, res;
  logic [15:0] tmr_r [N_OUT];
  logic [15:0] tmr_nxt [N_OUT];
  logic [$clog2(TICK_CYCLES+1)-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_step;
  logic [1:0] dest_nxt;
  logic refused_nxt;

  // standard net: every network n follows cam n, none follows a phys input
  function automatic plof_net_s std_net(input int n);
    plof_net_s s;
    s = '0;
    s.ct[0].used = 1'b1;
    s.ct[0].area = AREA_CAM;
    s.ct[0].num  = 5'(n);
    s.preset     = PRESET_RST;
    return s;
  endfunction : std_net

  // contact fetch over the eight signal areas
  function automatic logic fetch(input plof_contact_s c);
    logic v;
    case (c.area)
      AREA_IN:  v = phys_in[c.num];
      AREA_CAM: v = cam_out[c.num];
      AREA_OUT: v = 1'b0;
      default:  v = ext_regs[c.num];
    endcase
    return v ^ c.inv;
  endfunction : fetch

  function automatic logic is_timer(input plof_func_e f);
    return f inside {PLOF_PULSE_P, PLOF_PULSE_N, PLOF_EXT_P, PLOF_EXT_N,
                     PLOF_ONDLY_P, PLOF_OFFDLY_N};
  endfunction : is_timer

  // combined contact result: series AND, or_join opens a parallel branch
  always_comb begin
    logic br, acc;
    br = 1'b1;
    acc = 1'b0;
    res = '0;
    for (int n = 0; n < N_OUT; n++) begin
      br = 1'b1;
      acc = 1'b0;
      for (int k = 0; k < NET_CONTACTS; k++) begin
        if (nets_r[n].or_join[k]) begin
          acc = acc | br;
          br = 1'b1;
        end
        if (nets_r[n].ct[k].used) br = br & fetch(nets_r[n].ct[k]);
      end
      res[n] = acc | br;
    end
  end

  // 0.1 ms timebase
  always_comb begin
    tick_step = (tick_cnt_r == TICK_CYCLES - 1);
    tick_cnt_nxt = tick_step ? '0 : tick_cnt_r + 1'b1;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_nxt;
  end

  // output functions, one evaluation per scan
  always_comb begin
    logic aux, rise, fall;
    int   used;
    aux = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    used = 0;
    outs_nxt = outs_r;
    res_prev_nxt = res_prev_r;
    // refusal stands until the next scan re-judges the budget
    refused_nxt = timer_refused_r;
    for (int n = 0; n < N_OUT; n++) begin
      tmr_nxt[n] = tmr_r[n];
      if (tick_step && tmr_r[n] != 16'h0) tmr_nxt[n] = tmr_r[n] - 16'h1;
    end
    if (scan_tick) begin
      res_prev_nxt = res;
      refused_nxt = 1'b0;
      for (int n = 0; n < N_OUT; n++) begin
        aux  = fetch(nets_r[n].aux);
        rise = res[n] & ~res_prev_r[n];
        fall = ~res[n] & res_prev_r[n];
        if (is_timer(nets_r[n].func)) begin
          used = used + 1;
          if (BUDGET == 0 || used > BUDGET) refused_nxt = 1'b1;
        end
        case (nets_r[n].func)
          PLOF_STD: outs_nxt[n] = res[n];
          PLOF_SR: outs_nxt[n] = aux ? 1'b0 : (res[n] ? 1'b1 : outs_r[n]);
          PLOF_DL: outs_nxt[n] = aux ? res[n] : outs_r[n];
          PLOF_TG: outs_nxt[n] = aux ? 1'b0 : (res[n] ? ~outs_r[n] : outs_r[n]);
          PLOF_PULSE_P: begin
            if (rise) tmr_nxt[n] = nets_r[n].preset;
            else if (!res[n]) tmr_nxt[n] = 16'h0;
            outs_nxt[n] = rise ? (nets_r[n].preset != 0) : res[n] && tmr_r[n] != 0;
          end
          PLOF_PULSE_N: begin
            if (fall) tmr_nxt[n] = nets_r[n].preset;
            outs_nxt[n] = fall ? (nets_r[n].preset == 0) : tmr_r[n] == 0;
          end
          PLOF_EXT_P: begin
            if (rise) tmr_nxt[n] = nets_r[n].preset;
            outs_nxt[n] = rise ? (nets_r[n].preset != 0) : tmr_r[n] != 0;
          end
          PLOF_EXT_N: begin
            if (fall) tmr_nxt[n] = nets_r[n].preset;
            else if (res[n]) tmr_nxt[n] = 16'h0;
            outs_nxt[n] = res[n] ? 1'b1 : (fall ? (nets_r[n].preset == 0) : tmr_r[n] == 0);
          end
          PLOF_ONDLY_P: begin
            if (rise) tmr_nxt[n] = nets_r[n].preset;
            outs_nxt[n] = res[n] && !rise && tmr_r[n] == 0;
          end
          PLOF_OFFDLY_N: begin
            if (fall) tmr_nxt[n] = nets_r[n].preset;
            outs_nxt[n] = res[n] || (!fall && tmr_r[n] != 0);
          end
          default: outs_nxt[n] = res[n];
        endcase
        if (is_timer(nets_r[n].func) && (BUDGET == 0 || used > BUDGET)) outs_nxt[n] = 1'b0;
      end
    end
  end

  // keypad edits on the live network store
  always_comb begin
    for (int n = 0; n < N_OUT; n++) nets_nxt[n] = nets_r[n];
    clip_nxt = clip_r;
    undo_nxt = undo_r;
    undo_ok_nxt = undo_ok_r;
    undo_sel_nxt = undo_sel_r;
    dest_nxt = net_dest_r;
    if (32'(edit.sel) < N_OUT) begin
      dest_nxt = DEST_OUT;
      if (edit.write) begin
        nets_nxt[edit.sel] = edit.net;
        undo_ok_nxt = 1'b0;
      end else if (edit.erase) begin
        undo_nxt = nets_r[edit.sel];
        undo_sel_nxt = edit.sel;
        undo_ok_nxt = 1'b1;
        nets_nxt[edit.sel] = std_net(int'(edit.sel));
      end else if (edit.copy) begin
        clip_nxt = nets_r[edit.sel];
        undo_ok_nxt = 1'b0;
      end else if (edit.paste) begin
        if (undo_ok_r && undo_sel_r == edit.sel) begin
          nets_nxt[edit.sel] = undo_r;
          undo_ok_nxt = 1'b0;
        end else begin
          undo_nxt = nets_r[edit.sel];
          undo_sel_nxt = edit.sel;
          undo_ok_nxt = 1'b1;
          nets_nxt[edit.sel] = clip_r;
        end
      end else if (edit.other) begin
        undo_ok_nxt = 1'b0;
      end
    end
  end

  // destination flag; preset is 16 bits of 0.1 ms
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int n = 0; n < N_OUT; n++) begin
        nets_r[n] <= std_net(n);
        tmr_r[n]  <= '0;
      end
      clip_r <= '0;
      undo_r <= '0;
      undo_ok_r <= 1'b0;
      undo_sel_r <= '0;
      res_prev_r <= '0;
      outs_r <= '0;
      net_dest_r <= DEST_OUT;
      timer_refused_r <= 1'b0;
    end else begin
      for (int n = 0; n < N_OUT; n++) begin
        nets_r[n] <= nets_nxt[n];
        tmr_r[n]  <= tmr_nxt[n];
      end
      clip_r <= clip_nxt;
      undo_r <= undo_nxt;
      undo_ok_r <= undo_ok_nxt;
      undo_sel_r <= undo_sel_nxt;
      res_prev_r <= res_prev_nxt;
      outs_r <= outs_nxt;
      net_dest_r <= dest_nxt;
      timer_refused_r <= refused_nxt;
    end
  end

  // per-network checks, so the standard, set-reset, toggle and data-latch functions are watched on whichever network carries them
  for (genvar g = 0; g < N_OUT; g++) begin : g_chk
    sequence s_tg_scan;
      scan_tick && nets_r[g].func == PLOF_TG;
    endsequence
    property p_sr_reset;
      @(posedge mclk) disable iff (!reset_n)
      scan_tick && nets_r[g].func == PLOF_SR && fetch(nets_r[g].aux) |=> !outs_r[g];
    endproperty
    a_sr_reset: assert property (p_sr_reset) else $error("set-reset did not clear");
    property p_std;
      @(posedge mclk) disable iff (!reset_n)
      scan_tick && nets_r[g].func == PLOF_STD |=> outs_r[g] == $past(res[g]);
    endproperty
    a_std: assert property (p_std) else $error("standard output mismatch");
    property p_tg;
      @(posedge mclk) disable iff (!reset_n)
      s_tg_scan ##0 (!fetch(nets_r[g].aux) && res[g]) |=> outs_r[g] != $past(outs_r[g]);
    endproperty
    a_tg: assert property (p_tg) else $error("toggle did not invert");
    property p_tg_rst;
      @(posedge mclk) disable iff (!reset_n)
      s_tg_scan ##0 fetch(nets_r[g].aux) |=> !outs_r[g];
    endproperty
    a_tg_rst: assert property (p_tg_rst) else $error("toggle reset did not clear");
    property p_dl;
      @(posedge mclk) disable iff (!reset_n)
      scan_tick && nets_r[g].func == PLOF_DL && !fetch(nets_r[g].aux) |=> $stable(outs_r[g]);
    endproperty
    a_dl: assert property (p_dl) else $error("latch changed without strobe");
    property p_erase;
      @(posedge mclk) disable iff (!reset_n)
      edit.erase && !edit.write && edit.sel == 3'(g) |=> nets_r[g] == std_net(g);
    endproperty
    a_erase: assert property (p_erase) else $error("erase left no standard net");
  end
endmodule : plof_core
`default_nettype wire

/* File: sim/plof_io_model.sv */
`timescale 1ns/1ps
`default_nettype none
module plof_io_model #(
  parameter int PERIOD = 4
) (
  // clock and enable
  input  wire logic mclk,
  input  wire logic run,
  // scan strobe toward the block
  output logic      scan_tick
);
  int   cnt    = 0;
  logic tick_q = 1'b0;

  // one strobe per scan
  // launched on the falling edge so the block always samples it settled
  always @(negedge mclk) begin
    cnt    <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    tick_q <= run && (cnt == 0);
  end
  assign scan_tick = tick_q;
endmodule : plof_io_model
`default_nettype wire

/* File: sim/plc_output_function_logic_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module plc_output_function_logic_bench;
  import plof_pkg::*;
  logic        mclk;
  logic        reset_n;
  logic        run;
  logic        scan_tick;
  logic [31:0] phys_in;
  logic [31:0] cam_out;
  logic [31:0] ext_regs;
  plof_edit_s  edit;
  logic [7:0]  outs_r;
  logic [1:0]  net_dest_r;
  logic        timer_refused_r;
  int          mismatches = 0;
  int          n_checks   = 0;

  plof_io_model #(.PERIOD(4)) io (.mclk(mclk), .run(run), .scan_tick(scan_tick));

  // budget of one so a second timer is refused
  plof_core #(.N_OUT(8), .BUDGET(1)) dut (
    .mclk(mclk), .reset_n(reset_n), .scan_tick(scan_tick), .phys_in(phys_in),
    .cam_out(cam_out), .ext_regs(ext_regs), .edit(edit), .outs_r(outs_r),
    .net_dest_r(net_dest_r), .timer_refused_r(timer_refused_r)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // wait for a scan strobe, then one edge for the result to land
  task automatic scan();
    int i;
    i = 0;
    @(posedge mclk);
    while (scan_tick !== 1'b1 && i < 50) begin
      @(posedge mclk);
      i++;
    end
    if (i == 50) begin
      mismatches++;
      tally_and_finish();
    end
    @(posedge mclk);
    @(negedge mclk);
  endtask : scan

  // k = erase,copy,paste,other,write as one strobe cycle
  task automatic key(input logic [4:0] k, input logic [2:0] s, input plof_net_s n);
    @(negedge mclk);
    edit = {k, s, n};
    @(negedge mclk);
    edit = '0;
  endtask : key

  function automatic plof_net_s mk(input plof_func_e f, input logic [4:0] a,
                                   input logic [4:0] x, input logic [15:0] p);
    plof_net_s n;
    n        = '0;
    n.ct[0]  = {1'b1, 1'b0, AREA_IN, a};
    n.func   = f;
    n.aux    = {1'b1, 1'b0, AREA_IN, x};
    n.preset = p;
    return n;
  endfunction : mk

  // drive a two-bit input pair, scan, judge one output
  task automatic step(input int k, input int b, input logic [1:0] v, input logic e);
    phys_in[b +: 2] = v;
    scan();
    check(outs_r[k], e);
  endtask : step

  task automatic t_std();
    cam_out = 32'h000000a5;
    scan();
    for (int i = 0; i < 8; i++) check(outs_r[i], cam_out[i]);
    check(net_dest_r == DEST_OUT, 1'b1);
    cam_out = 32'h0;
  endtask : t_std

  task automatic t_funcs();
    key(5'h01, 3'h0, mk(PLOF_SR, 5'h0, 5'h1, 16'h0));
    key(5'h01, 3'h1, mk(PLOF_TG, 5'h2, 5'h3, 16'h0));
    key(5'h01, 3'h2, mk(PLOF_DL, 5'h4, 5'h5, 16'h0));
    step(0, 0, 2'b01, 1'b1);
    step(0, 0, 2'b00, 1'b1);
    step(0, 0, 2'b11, 1'b0);
    step(1, 2, 2'b11, 1'b0);
    step(1, 2, 2'b01, 1'b1);
    step(1, 2, 2'b01, 1'b0);
    step(1, 2, 2'b01, 1'b1);
    step(1, 2, 2'b00, 1'b1);
    step(1, 2, 2'b00, 1'b1);
    step(1, 2, 2'b11, 1'b0);
    step(2, 4, 2'b11, 1'b1);
    step(2, 4, 2'b10, 1'b0);
    step(2, 4, 2'b11, 1'b1);
    step(2, 4, 2'b01, 1'b1);
    step(2, 4, 2'b00, 1'b1);
  endtask : t_funcs

  // net0 is set-reset with set held; net2 latch gives 0
  task automatic t_edit();
    phys_in[5:4] = 2'b10;
    key(5'h10, 3'h0, '0);
    step(0, 0, 2'b01, 1'b0);
    key(5'h04, 3'h0, '0);
    step(0, 0, 2'b01, 1'b1);
    key(5'h08, 3'h2, '0);
    key(5'h04, 3'h0, '0);
    step(0, 0, 2'b01, 1'b0);
    key(5'h04, 3'h0, '0);
    step(0, 0, 2'b01, 1'b1);
    key(5'h10, 3'h0, '0);
    key(5'h02, 3'h0, '0);
    key(5'h04, 3'h0, '0);
    step(0, 0, 2'b01, 1'b0);
  endtask : t_edit

  // preset of 2 tenth-ms steps, 20000 cycles
  task automatic t_timer();
    key(5'h01, 3'h3, mk(PLOF_PULSE_P, 5'h6, 5'h1f, 16'h0002));
    key(5'h01, 3'h4, mk(PLOF_PULSE_P, 5'h6, 5'h1f, 16'h0002));
    step(3, 6, 2'b01, 1'b1);
    check(outs_r[4], 1'b0);
    check(timer_refused_r, 1'b1);
    repeat (1000) @(negedge mclk);
    step(3, 6, 2'b01, 1'b1);
    repeat (20000) @(negedge mclk);
    step(3, 6, 2'b01, 1'b0);
    step(3, 6, 2'b00, 1'b0);
    step(3, 6, 2'b01, 1'b1);
    step(3, 6, 2'b00, 1'b0);
  endtask : t_timer

  // two branches: (in8 and not in9) or (reg0 and cam5 on the ninth contact)
  task automatic t_net();
    plof_net_s n;
    n         = mk(PLOF_STD, 5'h8, 5'h0, 16'h0);
    n.ct[1]   = {1'b1, 1'b1, AREA_IN, 5'h9};
    n.ct[2]   = {1'b1, 1'b0, 3'h3, 5'h0};
    n.ct[8]   = {1'b1, 1'b0, AREA_CAM, 5'h5};
    n.or_join = 9'h004;
    key(5'h01, 3'h5, n);
    step(5, 8, 2'b01, 1'b1);
    step(5, 8, 2'b11, 1'b0);
    ext_regs = 32'h1;
    step(5, 8, 2'b00, 1'b0);
    cam_out = 32'h20;
    step(5, 8, 2'b00, 1'b1);
    ext_regs = 32'h0;
    cam_out  = 32'h0;
  endtask : t_net

  // preset of 3 steps: the first pulse is gone by 30000 cycles, the retrigger keeps it up
  task automatic t_ext_p();
    key(5'h01, 3'h4, mk(PLOF_STD, 5'h8, 5'h0, 16'h0));
    key(5'h01, 3'h3, mk(PLOF_EXT_P, 5'h6, 5'h1f, 16'h0003));
    step(3, 6, 2'b01, 1'b1);
    check(timer_refused_r, 1'b0);
    step(3, 6, 2'b00, 1'b1);
    repeat (15000) @(negedge mclk);
    step(3, 6, 2'b01, 1'b1);
    repeat (16000) @(negedge mclk);
    step(3, 6, 2'b01, 1'b1);
    repeat (14000) @(negedge mclk);
    step(3, 6, 2'b00, 1'b0);
  endtask : t_ext_p

  // preset of 1 step: the low window is over within 10000 cycles
  task automatic t_pulse_n();
    key(5'h01, 3'h3, mk(PLOF_PULSE_N, 5'h6, 5'h1f, 16'h0001));
    step(3, 6, 2'b01, 1'b1);
    step(3, 6, 2'b00, 1'b0);
    repeat (10001) @(negedge mclk);
    step(3, 6, 2'b00, 1'b1);
  endtask : t_pulse_n

  // low for at most one step, high again as soon as the result is true
  task automatic t_ext_n();
    key(5'h01, 3'h3, mk(PLOF_EXT_N, 5'h6, 5'h1f, 16'h0001));
    step(3, 6, 2'b01, 1'b1);
    step(3, 6, 2'b00, 1'b0);
    step(3, 6, 2'b01, 1'b1);
    step(3, 6, 2'b00, 1'b0);
    repeat (10001) @(negedge mclk);
    step(3, 6, 2'b00, 1'b1);
  endtask : t_ext_n

  initial begin
    reset_n  = 1'b0;
    run      = 1'b1;
    phys_in  = 32'h0;
    cam_out  = 32'h0;
    ext_regs = 32'h0;
    edit     = '0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    t_std();
    t_funcs();
    t_net();
    t_edit();
    t_timer();
    t_ext_p();
    t_pulse_n();
    t_ext_n();
    tally_and_finish();
  end
endmodule : plc_output_function_logic_bench
`default_nettype wire
